// File: design/btm_basic_timer.sv
// Basic 16-bit timer with prescaler, pin filter, toggle outputs and AXI4-Lite registers
//
// Operation
// - Toggle disabled: both toggle pins low
// - Toggle enabled: pins opposite, positive starts high
// - Each overflow inverts both toggle pins together
// - Two-bit mode field: counter mode, other three codes count as timer
// - Timer mode counts prescaled peripheral clock
// - Run bit starts counting per prescaled pulse
// - Count reaching reload signals overflow, sets flag
// - Interrupt only while overflow enable is set
// - Writing 0 to clear bit clears flag
// - Source select: 1 cascade, 0 external pin
// - External pin filtered, edge chosen by polarity
// - Counter mode counts prescaled source pulses
// - Timer period is (psc+1)*(reload+1) clocks
// - Divide by psc+1 clocked, psc on source
// - New prescale applies at overflow or start
// - Single shot stops, flags, clears run bit
// - Continuous mode wraps to zero and continues
`timescale 1ns/100ps
module btm_basic_timer
    import btm_pkg::*;
(
    input  wire logic          clock_i,
    input  wire logic          resetn_i,
    input  wire btm_axil_req_t axil_req_i,
    output btm_axil_rsp_t      axil_rsp_o,
    input  wire logic          internal_cascade_input_i,
    input  wire logic          external_trigger_pin_i,
    output logic               toggle_out_pos_o,
    output logic               toggle_out_neg_o,
    output logic               irq_o
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Byte-lane merge of a write into a register word
    function automatic logic [31:0] wmerge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Address decode shared by read and write paths
    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'b00) && (a <= BTM_OFF_CLEAR);
    endfunction

    btm_state_t st;
    btm_state_t next_st;

    logic        wr_go;
    logic        rd_go;
    logic        tick;
    logic        hit_reload;
    logic        src_pulse;
    logic [15:0] limit;
    logic [7:0]  n_mask;
    logic [7:0]  samp_top;
    logic [31:0] wword;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------

    // All timer, filter, flag and bus behaviour
    always_comb begin
        next_st    = st;
        wr_go      = st.aw_held && st.w_held && !st.rsp.bvalid;
        rd_go      = axil_req_i.arvalid && st.rsp.arready;
        tick       = 1'b0;
        hit_reload = 1'b0;
        src_pulse  = 1'b0;
        wword      = 32'h0000_0000;

        // Pin filter: sample every 2^k clocks, N equal samples change level
        samp_top = 8'h01 << st.pin_filter_setting[3:2];
        samp_top = samp_top - 8'h01;
        n_mask   = (st.pin_filter_setting[1:0] == 2'b00) ? 8'h01 :
                   ((8'h01 << {st.pin_filter_setting[1:0], 1'b0}) - 8'h01);
        if (st.samp_cnt >= samp_top) begin
            next_st.samp_cnt = 8'h00;
            next_st.hist     = {st.hist[6:0], external_trigger_pin_i};
        end else begin
            next_st.samp_cnt = st.samp_cnt + 8'h01;
        end
        if ((st.hist & n_mask) == n_mask) begin
            next_st.filt_lvl = 1'b1;
        end else if ((st.hist & n_mask) == 8'h00) begin
            next_st.filt_lvl = 1'b0;
        end
        next_st.cascade_prev = internal_cascade_input_i;

        // Counting source: cascade rising edge or filtered pin edge
        if (st.ctrl.count_source_select) begin
            src_pulse = internal_cascade_input_i && !st.cascade_prev;
        end else begin
            src_pulse = st.ctrl.edge_polarity_select ?
                        (!next_st.filt_lvl && st.filt_lvl) :
                        (next_st.filt_lvl && !st.filt_lvl);
        end

        // Prescaler: clock mode divides by psc+1, source mode by psc
        if (st.ctrl.mode == BTM_MODE_COUNTER) begin
            limit = (st.prescale_active == 16'h0000) ? 16'h0000 :
                    st.prescale_active - 16'h0001;
        end else begin
            limit     = st.prescale_active;
            src_pulse = 1'b1;
        end
        next_st.reload_overflow = 1'b0;
        if (st.ctrl.run && src_pulse) begin
            if (st.pre_cnt >= limit) begin
                next_st.pre_cnt = 16'h0000;
                tick            = 1'b1;
            end else begin
                next_st.pre_cnt = st.pre_cnt + 16'h0001;
            end
        end

        // Up counter with reload, wrap and single shot
        if (tick) begin
            if (st.count_value == st.reload_value) begin
                hit_reload              = 1'b1;
                next_st.count_value     = 16'h0000;
                next_st.reload_overflow = 1'b1;
                next_st.prescale_active = st.prescale_setting;
                if (st.ctrl.single_shot_select) begin
                    next_st.ctrl.run = 1'b0;
                end
            end else if (st.count_value > st.reload_value) begin
                next_st.count_value = 16'h0000;
            end else begin
                next_st.count_value = st.count_value + 16'h0001;
            end
        end

        // Write channel capture, either order
        if (axil_req_i.awvalid && st.rsp.awready) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = axil_req_i.awaddr;
        end
        if (axil_req_i.wvalid && st.rsp.wready) begin
            next_st.w_held = 1'b1;
            next_st.w_data = axil_req_i.wdata;
            next_st.w_strb = axil_req_i.wstrb;
        end

        // Status read clears the flag
        if (rd_go && axil_req_i.araddr == BTM_OFF_STATUS) begin
            next_st.flag = 1'b0;
        end

        // Register write
        if (wr_go) begin
            next_st.aw_held    = 1'b0;
            next_st.w_held     = 1'b0;
            next_st.rsp.bvalid = 1'b1;
            next_st.rsp.bresp  = mapped(st.aw_addr) ? BTM_RESP_OKAY : BTM_RESP_SLVERR;
            unique case (st.aw_addr)
                BTM_OFF_CTRL: begin
                    wword        = wmerge({25'h0, st.ctrl}, st.w_data, st.w_strb);
                    next_st.ctrl = wword[6:0];
                    if (wword[0] && !st.ctrl.run) begin
                        next_st.prescale_active = st.prescale_setting;
                        next_st.pre_cnt         = 16'h0000;
                    end
                end
                BTM_OFF_PSC: begin
                    wword = wmerge({16'h0, st.prescale_setting}, st.w_data, st.w_strb);
                    next_st.prescale_setting = wword[15:0];
                end
                BTM_OFF_RELOAD: begin
                    wword = wmerge({16'h0, st.reload_value}, st.w_data, st.w_strb);
                    next_st.reload_value = wword[15:0];
                end
                BTM_OFF_COUNT: begin
                    wword = wmerge({16'h0, st.count_value}, st.w_data, st.w_strb);
                    next_st.count_value = wword[15:0];
                end
                BTM_OFF_FILTER: begin
                    wword = wmerge({28'h0, st.pin_filter_setting}, st.w_data, st.w_strb);
                    next_st.pin_filter_setting = wword[3:0];
                end
                BTM_OFF_IRQEN: begin
                    if (st.w_strb[0]) begin
                        next_st.irq_en = st.w_data[BTM_FLAG_BIT];
                    end
                end
                BTM_OFF_CLEAR: begin
                    if (st.w_strb[0] && !st.w_data[BTM_FLAG_BIT]) begin
                        next_st.flag = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (st.rsp.bvalid && axil_req_i.bready) begin
            next_st.rsp.bvalid = 1'b0;
        end

        // Overflow pulse sets the flag; set wins over clear
        if (st.reload_overflow) begin
            next_st.flag = 1'b1;
        end
        next_st.irq = next_st.flag && next_st.irq_en;

        // Read channel
        if (rd_go) begin
            next_st.rsp.rvalid = 1'b1;
            next_st.rsp.rresp  = mapped(axil_req_i.araddr) ? BTM_RESP_OKAY :
                                 BTM_RESP_SLVERR;
            unique case (axil_req_i.araddr)
                BTM_OFF_CTRL:   next_st.rsp.rdata = {25'h0, st.ctrl};
                BTM_OFF_PSC:    next_st.rsp.rdata = {16'h0, st.prescale_setting};
                BTM_OFF_RELOAD: next_st.rsp.rdata = {16'h0, st.reload_value};
                BTM_OFF_COUNT:  next_st.rsp.rdata = {16'h0, st.count_value};
                BTM_OFF_FILTER: next_st.rsp.rdata = {28'h0, st.pin_filter_setting};
                BTM_OFF_STATUS: next_st.rsp.rdata = {31'h0, st.flag};
                BTM_OFF_IRQEN:  next_st.rsp.rdata = {31'h0, st.irq_en};
                default:        next_st.rsp.rdata = 32'h0000_0000;
            endcase
        end else if (st.rsp.rvalid && axil_req_i.rready) begin
            next_st.rsp.rvalid = 1'b0;
        end
        next_st.rsp.awready = !next_st.aw_held && !next_st.rsp.bvalid;
        next_st.rsp.wready  = !next_st.w_held && !next_st.rsp.bvalid;
        next_st.rsp.arready = !next_st.rsp.rvalid;

        // Toggle pair: low when off, positive high on enable, invert on overflow
        if (!next_st.ctrl.flip_output_enable) begin
            next_st.tog_pos = 1'b0;
            next_st.tog_neg = 1'b0;
        end else if (!st.ctrl.flip_output_enable) begin
            next_st.tog_pos = 1'b1;
            next_st.tog_neg = 1'b0;
        end else if (st.reload_overflow) begin
            next_st.tog_pos = !st.tog_pos;
            next_st.tog_neg = !st.tog_neg;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------

    // Single register for all state, toggle levels included
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st                  <= '0;
            st.prescale_setting <= BTM_RST_PSC;
            st.prescale_active  <= BTM_RST_PSC;
            st.reload_value     <= BTM_RST_RELOAD;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flops
    assign axil_rsp_o       = st.rsp;
    assign toggle_out_pos_o = st.tog_pos;
    assign toggle_out_neg_o = st.tog_neg;
    assign irq_o            = st.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    sequence s_reach;
        tick && hit_reload && !wr_go;
    endsequence
    sequence s_pulse_then_flag;
        ##1 st.reload_overflow ##1 st.flag;
    endsequence

    a_flip_off_low: assert property (!st.ctrl.flip_output_enable |->
        !toggle_out_pos_o && !toggle_out_neg_o) else $error("toggle pins not low");
    a_flip_on_pair: assert property (st.ctrl.flip_output_enable |->
        toggle_out_pos_o != toggle_out_neg_o) else $error("toggle pins not opposite");
    a_flip_on_ovf: assert property (st.reload_overflow &&
        st.ctrl.flip_output_enable && next_st.ctrl.flip_output_enable |=>
        toggle_out_pos_o != $past(toggle_out_pos_o)) else $error("no toggle on overflow");
    a_ovf_flag_set: assert property (s_reach |-> s_pulse_then_flag)
        else $error("overflow did not set flag");
    a_irq_masked: assert property (irq_o == (st.flag && st.irq_en))
        else $error("interrupt not gated by enable");
    a_clear_flag: assert property (wr_go && st.aw_addr == BTM_OFF_CLEAR &&
        st.w_strb[0] && !st.w_data[0] && !st.reload_overflow |=> !st.flag)
        else $error("clear write left flag set");
    a_single_stop: assert property ((s_reach and st.ctrl.single_shot_select) |=>
        !st.ctrl.run && st.count_value == 16'h0000) else $error("single shot kept running");
    a_wrap_zero: assert property (s_reach |=> st.count_value == 16'h0000)
        else $error("no wrap to zero");
    a_count_step: assert property (tick && !hit_reload && !wr_go &&
        st.count_value < st.reload_value |=> st.count_value == $past(st.count_value) + 16'h0001)
        else $error("counter did not step");
    a_timer_div: assert property (st.ctrl.run && st.ctrl.mode == BTM_MODE_TIMER &&
        st.pre_cnt == 16'h0000 && st.prescale_active == 16'h0001 && !wr_go |->
        !tick ##1 tick) else $error("timer prescale wrong");

endmodule

// File: include/btm_pkg.sv
// Package of constants and types for the basic timer block
package btm_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] BTM_OFF_CTRL   = 8'h00;
    localparam logic [7:0] BTM_OFF_PSC    = 8'h04;
    localparam logic [7:0] BTM_OFF_RELOAD = 8'h08;
    localparam logic [7:0] BTM_OFF_COUNT  = 8'h0C;
    localparam logic [7:0] BTM_OFF_FILTER = 8'h10;
    localparam logic [7:0] BTM_OFF_STATUS = 8'h14;
    localparam logic [7:0] BTM_OFF_IRQEN  = 8'h18;
    localparam logic [7:0] BTM_OFF_CLEAR  = 8'h1C;

    // ------------------------------------------------------------
    // Reset values and answers
    // ------------------------------------------------------------
    localparam logic [15:0] BTM_RST_PSC    = 16'h0000;
    localparam logic [15:0] BTM_RST_RELOAD = 16'hFFFF;
    localparam logic [1:0]  BTM_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  BTM_RESP_SLVERR = 2'h2;
    localparam int unsigned BTM_FLAG_BIT   = 0;

    // Operating mode field
    typedef enum logic [1:0] {
        BTM_MODE_TIMER   = 2'b00,
        BTM_MODE_COUNTER = 2'b01,
        BTM_MODE_TRIGGER = 2'b10,
        BTM_MODE_GATED   = 2'b11
    } btm_mode_t;

    // Control register layout, run enable in bit 0
    typedef struct packed {
        logic      flip_output_enable;
        logic      edge_polarity_select;
        logic      count_source_select;
        logic      single_shot_select;
        btm_mode_t mode;
        logic      run;
    } btm_ctrl_t;

    // AXI4-Lite request from master
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } btm_axil_req_t;

    // AXI4-Lite answer to master
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } btm_axil_rsp_t;

    // Whole state of the timer
    typedef struct packed {
        btm_ctrl_t     ctrl;
        logic [15:0]   prescale_setting;
        logic [15:0]   prescale_active;
        logic [15:0]   pre_cnt;
        logic [15:0]   reload_value;
        logic [15:0]   count_value;
        logic [3:0]    pin_filter_setting;
        logic [7:0]    samp_cnt;
        logic [7:0]    hist;
        logic          filt_lvl;
        logic          cascade_prev;
        logic          reload_overflow;
        logic          flag;
        logic          irq_en;
        logic          irq;
        logic          tog_pos;
        logic          tog_neg;
        logic          aw_held;
        logic [7:0]    aw_addr;
        logic          w_held;
        logic [31:0]   w_data;
        logic [3:0]    w_strb;
        btm_axil_rsp_t rsp;
    } btm_state_t;

endpackage

// File: sim/btm_far_model.sv
// Far-side model: trigger pin and cascade source, toggle pin watcher
`timescale 1ns/100ps
module btm_far_model (
    input  wire logic clock_i,
    input  wire logic toggle_out_pos_i,
    output logic      pin_o,
    output logic      cascade_o,
    output int        flip_gap_o
);
    int   run_len;
    logic last_pos;

    // Both sources idle low; the pin is a push-pull driver
    initial begin
        pin_o = 1'b0;
        cascade_o = 1'b0;
        flip_gap_o = 0;
        run_len = 0;
        last_pos = 1'b0;
    end

    // Clocks between inversions, sampled where outputs are settled
    always @(negedge clock_i) begin
        if (toggle_out_pos_i !== last_pos) begin
            flip_gap_o <= run_len;
            run_len <= 1;
        end else begin
            run_len <= run_len + 1;
        end
        last_pos <= toggle_out_pos_i;
    end

    // Whole pulses, long enough to pass the pin filter
    task automatic pulse(input logic on_pin, input int n);
        repeat (n) begin
            @(posedge clock_i);
            if (on_pin) begin
                pin_o <= 1'b1;
            end else begin
                cascade_o <= 1'b1;
            end
            repeat (8) @(posedge clock_i);
            pin_o <= 1'b0;
            cascade_o <= 1'b0;
            repeat (8) @(posedge clock_i);
        end
    endtask
endmodule

// File: sim/basic_timer_modes_toggle_tb.sv
// Self-checking bench for the basic timer
`timescale 1ns/100ps
module basic_timer_modes_toggle_tb
    import btm_pkg::*;
;
    logic          clock_i;
    logic          resetn_i;
    btm_axil_req_t req;
    btm_axil_rsp_t rsp;
    logic          pos;
    logic          neg;
    logic          irq;
    logic          pin;
    logic          casc;
    int            gap;
    int            mismatches;
    int            tests_run;
    logic [31:0]   rd;
    logic [1:0]    resp;

    btm_basic_timer i_dut (
        .clock_i                  (clock_i),
        .resetn_i                 (resetn_i),
        .axil_req_i               (req),
        .axil_rsp_o               (rsp),
        .internal_cascade_input_i (casc),
        .external_trigger_pin_i   (pin),
        .toggle_out_pos_o         (pos),
        .toggle_out_neg_o         (neg),
        .irq_o                    (irq)
    );

    btm_far_model i_far (
        .clock_i          (clock_i),
        .toggle_out_pos_i (pos),
        .pin_o            (pin),
        .cascade_o        (casc),
        .flip_gap_o       (gap)
    );

    // ----------------------------------------
    // Bus tasks and checks
    // ----------------------------------------
    always #20 clock_i = ~clock_i;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        logic b_ok;
        @(posedge clock_i);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.bready <= 1'b1;
        forever begin
            @(negedge clock_i);
            aw_ok = req.awvalid & rsp.awready;
            w_ok = req.wvalid & rsp.wready;
            b_ok = rsp.bvalid;
            resp = rsp.bresp;
            @(posedge clock_i);
            if (aw_ok) req.awvalid <= 1'b0;
            if (w_ok) req.wvalid <= 1'b0;
            if (b_ok) begin
                req.bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd_reg(input logic [7:0] a);
        logic ar_ok;
        logic r_ok;
        @(posedge clock_i);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        forever begin
            @(negedge clock_i);
            ar_ok = req.arvalid & rsp.arready;
            r_ok = rsp.rvalid;
            rd = rsp.rdata;
            resp = rsp.rresp;
            @(posedge clock_i);
            if (ar_ok) req.arvalid <= 1'b0;
            if (r_ok) begin
                req.rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic wait_irq();
        for (int i = 0; i < 300 && irq !== 1'b1; i++) @(negedge clock_i);
    endtask

    task automatic close_out();
        if (mismatches == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    initial begin
        #(40 * 20000);
        mismatches++;
        close_out();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        clock_i = 1'b0;
        resetn_i = 1'b0;
        req = '0;
        mismatches = 0;
        tests_run = 0;
        repeat (10) @(posedge clock_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rd_reg(BTM_OFF_RELOAD);
        chk(rd, 32'h0000_FFFF);
        rd_reg(8'h20);
        chk({30'h0000_0000, resp}, {30'h0000_0000, BTM_RESP_SLVERR});
        chk(rd, 32'h0000_0000);
        // Unaligned write refused and ignored
        wr(8'h22, 32'h0000_0001);
        chk({30'h0000_0000, resp}, {30'h0000_0000, BTM_RESP_SLVERR});
        rd_reg(BTM_OFF_CTRL);
        chk(rd, 32'h0000_0000);
        for (int m = 0; m < 4; m++) begin
            wr(BTM_OFF_CTRL, 32'(m << 1));
            rd_reg(BTM_OFF_CTRL);
            chk(rd, 32'(m << 1));
        end
        // Toggle enabled, idle: positive high, negative low
        wr(BTM_OFF_CTRL, 32'h0000_0040);
        repeat (2) @(negedge clock_i);
        chk({30'h0000_0000, pos, neg}, 32'h0000_0002);
        // Continuous timer, period (1+1)*(3+1)
        wr(BTM_OFF_PSC, 32'h0000_0001);
        chk({30'h0000_0000, resp}, {30'h0000_0000, BTM_RESP_OKAY});
        wr(BTM_OFF_RELOAD, 32'h0000_0003);
        wr(BTM_OFF_IRQEN, 32'h0000_0001);
        wr(BTM_OFF_CTRL, 32'h0000_0041);
        wait_irq();
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        repeat (40) @(negedge clock_i);
        chk(gap, 32'h0000_0008);
        chk({31'h0000_0000, pos ^ neg}, 32'h0000_0001);
        wr(BTM_OFF_PSC, 32'h0000_0003);
        repeat (80) @(negedge clock_i);
        chk(gap, 32'h0000_0010);
        // Stop, then status read clears the flag
        wr(BTM_OFF_CTRL, 32'h0000_0040);
        rd_reg(BTM_OFF_STATUS);
        chk(rd, 32'h0000_0001);
        rd_reg(BTM_OFF_STATUS);
        chk(rd, 32'h0000_0000);
        @(negedge clock_i);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        // Single shot clears run and wraps count
        wr(BTM_OFF_COUNT, 32'h0000_0000);
        wr(BTM_OFF_CTRL, 32'h0000_0049);
        wait_irq();
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        rd_reg(BTM_OFF_CTRL);
        chk(rd, 32'h0000_0048);
        rd_reg(BTM_OFF_COUNT);
        chk(rd, 32'h0000_0000);
        // Masked flag, then clear by writing zero
        wr(BTM_OFF_IRQEN, 32'h0000_0000);
        repeat (2) @(negedge clock_i);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        wr(BTM_OFF_CLEAR, 32'h0000_0000);
        wr(BTM_OFF_IRQEN, 32'h0000_0001);
        repeat (2) @(negedge clock_i);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        rd_reg(BTM_OFF_STATUS);
        chk(rd, 32'h0000_0000);
        // Toggle disabled drives both low
        wr(BTM_OFF_CTRL, 32'h0000_0000);
        repeat (2) @(negedge clock_i);
        chk({30'h0000_0000, pos, neg}, 32'h0000_0000);
        // Counter mode on cascade, divide by setting
        wr(BTM_OFF_PSC, 32'h0000_0002);
        wr(BTM_OFF_RELOAD, 32'h0000_000F);
        wr(BTM_OFF_COUNT, 32'h0000_0000);
        wr(BTM_OFF_CTRL, 32'h0000_0013);
        i_far.pulse(1'b0, 6);
        i_far.pulse(1'b1, 2);
        repeat (4) @(posedge clock_i);
        rd_reg(BTM_OFF_COUNT);
        chk(rd, 32'h0000_0003);
        // Counter mode on filtered pin, falling edges
        wr(BTM_OFF_CTRL, 32'h0000_0022);
        wr(BTM_OFF_PSC, 32'h0000_0001);
        wr(BTM_OFF_FILTER, 32'h0000_0005);
        wr(BTM_OFF_COUNT, 32'h0000_0000);
        wr(BTM_OFF_CTRL, 32'h0000_0023);
        i_far.pulse(1'b1, 5);
        i_far.pulse(1'b0, 3);
        repeat (8) @(posedge clock_i);
        rd_reg(BTM_OFF_COUNT);
        chk(rd, 32'h0000_0005);
        close_out();
    end
endmodule
